// file: mfp_pin_mode.sv
// mode register for pins 0 to 2 plus output styles and input merging
// assumes a write port from the serial interface; bits 7:6 owned elsewhere
`timescale 1ns/100ps
`default_nettype none
`include "mfp_defs.svh"
module mfp_pin_mode #(
  parameter int PINS  = 3,
  parameter int FUNCS = 4
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire logic                 regWrite,
  input  wire logic [7:0]           regWrData,
  output var  logic [7:0]           regRdData,
  input  wire logic [PINS-1:0]      pinOutputMode,
  input  wire logic [PINS-1:0]      pinStatus,
  input  wire logic [PINS*2-1:0]    pinFunction,
  input  wire logic [PINS-1:0]      pinIn,
  output var  logic [PINS-1:0]      pinOut,
  output var  logic [PINS-1:0]      pinOe,
  output var  logic [FUNCS-1:0]     controlFunction
);
  import mfp_pkg::*;
  if (PINS != 3) begin : gBadPins
    $error("PINS must be 3");
  end
  if (FUNCS < 1 || FUNCS > 4) begin : gBadFuncs
    $error("FUNCS must be 1 to 4");
  end
  logic [7:0]             pinModeLow_reg;
  logic [PINS-1:0]        assigned [FUNCS];
  logic [FUNCS-1:0]       controlFunction_next;
  // -------------------------------------------
  // mode register
  // -------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pinModeLow_reg <= `MFP_MODE_RESET;
    end else if (regWrite) begin
      pinModeLow_reg <= regWrData & `MFP_LOW_MASK;
    end
  end
  assign regRdData = pinModeLow_reg;
  // -------------------------------------------
  // per-pin output stage
  // -------------------------------------------
  genvar gp;
  generate
    for (gp = 0; gp < PINS; gp++) begin : gPin
      mfp_drive_s drive;
      logic [1:0] field;
      assign field = pinModeLow_reg[gp*2 +: 2];
      mfp_pin_driver uDrv (
        .sys_clk (sys_clk),
        .rst     (rst),
        .style   (mfp_style_e'(field)),
        .status  (pinStatus[gp]),
        .drive   (drive)
      );
      assign pinOut[gp] = drive.out;
      assign pinOe[gp]  = drive.oe & pinOutputMode[gp];
    end
  endgenerate
  // -------------------------------------------
  // input merging per control function
  // -------------------------------------------
  always_comb begin
    for (int f = 0; f < FUNCS; f++) begin
      for (int p = 0; p < PINS; p++) begin
        assigned[f][p] = !pinOutputMode[p] && pinFunction[p*2 +: 2] == 2'(f);
      end
    end
  end
  always_comb begin
    logic allHi;
    logic allLo;
    logic oneHi;
    logic oneLo;
    allHi = 1'b1;
    allLo = 1'b1;
    oneHi = 1'b0;
    oneLo = 1'b0;
    controlFunction_next = '0;
    for (int f = 0; f < FUNCS; f++) begin
      allHi = 1'b1;
      allLo = 1'b1;
      oneHi = 1'b0;
      oneLo = 1'b0;
      for (int p = 0; p < PINS; p++) begin
        if (assigned[f][p]) begin
          allHi = allHi & pinIn[p];
          allLo = allLo & ~pinIn[p];
          oneHi = oneHi | pinIn[p];
          oneLo = oneLo | ~pinIn[p];
        end
      end
      // lowest assigned pin's field chooses the merge
      for (int p = PINS - 1; p >= 0; p--) begin
        if (assigned[f][p]) begin
          case (mfp_combine_e'(pinModeLow_reg[p*2 +: 2]))
            MFP_IN_AND_TRUE: controlFunction_next[f] = allHi;
            MFP_IN_AND_INV:  controlFunction_next[f] = allLo;
            MFP_IN_OR_TRUE:  controlFunction_next[f] = oneHi;
            MFP_IN_OR_INV:   controlFunction_next[f] = oneLo;
            default:         controlFunction_next[f] = 1'b0;
          endcase
        end
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      controlFunction <= '0;
    end else begin
      controlFunction <= controlFunction_next;
    end
  end
  // -------------------------------------------
  // checks
  // -------------------------------------------
  sequence sWrite;
    regWrite;
  endsequence
  chk_mode_readback: assert property (@(posedge sys_clk) disable iff (rst)
    sWrite |=> regRdData == ($past(regWrData) & `MFP_LOW_MASK))
    else $error("mode readback differs from write");
  chk_upper_zero: assert property (@(posedge sys_clk) disable iff (rst)
    regRdData[7:6] == 2'b00)
    else $error("upper bits not zero");
  chk_reset_fields: assert property (@(posedge sys_clk)
    rst |=> regRdData == `MFP_MODE_RESET)
    else $error("mode fields not cleared by reset");
  chk_input_released: assert property (@(posedge sys_clk) disable iff (rst)
    !pinOutputMode[0] |-> !pinOe[0])
    else $error("input pin driven");
  chk_unassigned_idle: assert property (@(posedge sys_clk) disable iff (rst)
    (assigned[0] == '0) |=> !controlFunction[0])
    else $error("unassigned function asserted");
endmodule
`default_nettype wire

// file: mfp_defs.svh
// constants for the multifunction pin mode logic, pins 0 to 2
// assumes inclusion by the package and the design modules
// What this block does
// - pin 2 mode field sits in bits 5:4, resets to zero
// - pin 1 mode field sits in bits 3:2, resets to zero
// - pin 0 mode field sits in bits 1:0, resets to zero
// - output field 00: push-pull, asserted status drives high
// - output field 01: push-pull, asserted status drives low
// - output field 10: drive high only when asserted, else release
// - output field 11: drive low only when asserted, else release
// - output field selects polarity and allows wired AND or OR
// - input field selects how same-function pins merge; reset is AND true
// - input field 00: function true while all assigned pins high
// - input field 01: function true while all assigned pins low
// - input field 10: function true while any assigned pin high
// - input field 11: function true while any assigned pin low
// - software reads back each written 2-bit mode field
`ifndef MFP_DEFS_SVH
`define MFP_DEFS_SVH
`define MFP_REG_WIDTH    8
`define MFP_FIELD_WIDTH  2
`define MFP_PIN0_LSB     0
`define MFP_PIN1_LSB     2
`define MFP_PIN2_LSB     4
`define MFP_LOW_MASK     8'h3F
`define MFP_MODE_RESET   8'h00
`define MFP_FIELD_RESET  2'h0
`endif

// file: mfp_pkg.sv
// types for the multifunction pin mode logic
// assumes mfp_defs.svh is on the include path
`include "mfp_defs.svh"
package mfp_pkg;
  typedef enum logic [1:0] {
    MFP_OUT_TRUE    = 2'b00,
    MFP_OUT_INVERT  = 2'b01,
    MFP_OUT_HIGHONLY = 2'b10,
    MFP_OUT_LOWONLY = 2'b11
  } mfp_style_e;
  typedef enum logic [1:0] {
    MFP_IN_AND_TRUE = 2'b00,
    MFP_IN_AND_INV  = 2'b01,
    MFP_IN_OR_TRUE  = 2'b10,
    MFP_IN_OR_INV   = 2'b11
  } mfp_combine_e;
  typedef struct packed {
    logic out;
    logic oe;
  } mfp_drive_s;
endpackage

// file: mfp_pin_driver.sv
// one pin's output stage: style field to level and enable
// assumes status is a synchronous level from the device core
`timescale 1ns/100ps
`default_nettype none
module mfp_pin_driver (
  input  wire logic               sys_clk,
  input  wire logic               rst,
  input  wire mfp_pkg::mfp_style_e style,
  input  wire logic               status,
  output var  mfp_pkg::mfp_drive_s drive
);
  import mfp_pkg::*;
  // -------------------------------------------
  // output style decode
  // -------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      drive <= '0;
    end else begin
      case (style)
        MFP_OUT_TRUE:     drive <= '{out: status, oe: 1'b1};
        MFP_OUT_INVERT:   drive <= '{out: ~status, oe: 1'b1};
        MFP_OUT_HIGHONLY: drive <= '{out: 1'b1, oe: status};
        MFP_OUT_LOWONLY:  drive <= '{out: 1'b0, oe: status};
        default:          drive <= '0;
      endcase
    end
  end
  // -------------------------------------------
  // checks
  // -------------------------------------------
  chk_true_drive: assert property (@(posedge sys_clk) disable iff (rst)
    style == MFP_OUT_TRUE |=> drive.oe && drive.out == $past(status))
    else $error("true style drive wrong");
  chk_invert_drive: assert property (@(posedge sys_clk) disable iff (rst)
    style == MFP_OUT_INVERT |=> drive.oe && drive.out != $past(status))
    else $error("inverted style drive wrong");
  chk_high_only: assert property (@(posedge sys_clk) disable iff (rst)
    style == MFP_OUT_HIGHONLY |=> drive.oe == $past(status) && drive.out)
    else $error("high-only style drive wrong");
  chk_low_only: assert property (@(posedge sys_clk) disable iff (rst)
    style == MFP_OUT_LOWONLY |=> drive.oe == $past(status) && !drive.out)
    else $error("low-only style drive wrong");
endmodule
`default_nettype wire

// file: mfp_board.sv
// board model: pull resistors and external drivers on pins 0 to 2
// assumes pinOe high means the device drives the pin
`timescale 1ns/100ps
`default_nettype none
module mfp_board (
  input  wire logic [2:0] pinOut,
  input  wire logic [2:0] pinOe,
  input  wire logic [2:0] pullUp,
  input  wire logic [2:0] extEn,
  input  wire logic [2:0] extVal,
  output var  logic [2:0] pinLevel
);
  // released pin takes its external driver's value when extEn is set, else its pull level
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pinLevel[i] = pinOe[i] ? pinOut[i] : (extEn[i] ? extVal[i] : pullUp[i]);
    end
  end
endmodule
`default_nettype wire

// file: mfp_pin_mode_test.sv
// self-checking bench for the pin mode logic
// assumes mfp_board models the far side of the pins
`timescale 1ns/100ps
`default_nettype none
module mfp_pin_mode_test;
  logic       sys_clk = 1'b0;
  logic       rst = 1'b1;
  logic       regWrite = 1'b0;
  logic [7:0] regWrData = 8'h00;
  logic [2:0] outMode = 3'h0, status = 3'h0, pullUp = 3'h0, extEn = 3'h0, extVal = 3'h0;
  logic [5:0] func = 6'h00;
  logic [7:0] rdData;
  logic [2:0] pinOut, pinOe, level, sv, pm;
  logic [3:0] ctrl;
  int         errTotal = 0, checkCount = 0, cycles = 0;
  always #5 sys_clk = ~sys_clk;
  mfp_pin_mode dut_u (.sys_clk(sys_clk), .rst(rst), .regWrite(regWrite),
    .regWrData(regWrData), .regRdData(rdData), .pinOutputMode(outMode),
    .pinStatus(status), .pinFunction(func), .pinIn(level), .pinOut(pinOut),
    .pinOe(pinOe), .controlFunction(ctrl));
  mfp_board board_u (.pinOut(pinOut), .pinOe(pinOe), .pullUp(pullUp),
    .extEn(extEn), .extVal(extVal), .pinLevel(level));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic printVerdict();
    $display("checks %0d mismatches %0d", checkCount, errTotal);
    if (errTotal == 0 && checkCount > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checkCount++;
    if (seen !== exp) begin
      errTotal++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrReg(input logic [7:0] d);
    @(posedge sys_clk);
    regWrite <= 1'b1;
    regWrData <= d;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask
  task automatic settle();
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  function automatic logic mergeExp(input int m, input logic [2:0] x, input logic [2:0] p);
    case (m)
      0: return &(x | ~p);
      1: return &(~x | ~p);
      2: return |(x & p);
      default: return |(~x & p);
    endcase
  endfunction
  // ----------------------------------------
  // timeout
  // ----------------------------------------
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errTotal++;
      printVerdict();
    end
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    settle();
    check("reset", rdData, 8'h00);
    wrReg(8'hFF);
    settle();
    check("upper", rdData, 8'h3F);
    wrReg(8'h24);
    settle();
    check("fields", rdData, 8'h24);
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    settle();
    check("rereset", rdData, 8'h00);
    for (int s = 0; s < 4; s++) begin
      wrReg({2'h0, s[1:0], s[1:0], s[1:0]});
      for (int st = 0; st < 2; st++) begin
        sv = st[0] ? 3'h5 : 3'h2;
        @(posedge sys_clk);
        outMode <= 3'h7;
        pullUp <= (s == 3) ? 3'h7 : 3'h0;
        status <= sv;
        settle();
        check("enable", {5'h00, pinOe}, {5'h00, (s < 2) ? 3'h7 : sv});
        check("level", {5'h00, level}, {5'h00, s[0] ? ~sv : sv});
      end
    end
    for (int m = 0; m < 4; m++) begin
      wrReg({2'h0, m[1:0], m[1:0], m[1:0]});
      for (int v = 0; v < 16; v++) begin
        pm = v[3] ? 3'h6 : 3'h7;
        @(posedge sys_clk);
        outMode <= {2'h0, v[3]};
        func <= 6'h15;
        extEn <= 3'h7;
        extVal <= v[2:0];
        settle();
        check("merge", {4'h0, ctrl}, {6'h00, mergeExp(m, v[2:0], pm), 1'h0});
      end
    end
    printVerdict();
  end
endmodule
`default_nettype wire
